// ==== hw/ecwc_pkg.sv ====
package ecwc_pkg;
  // line type codes carried in the three data bits of the command byte
  localparam logic [2:0] LT_END = 3'h0;
  localparam logic [2:0] LT_BLANK = 3'h1;
  localparam logic [2:0] LT_BLACK = 3'h2;
  localparam logic [2:0] LT_VISIBLE = 3'h3;
  localparam logic [2:0] LT_EVEN_START = 3'h4;
  localparam logic [2:0] LT_EVEN_END = 3'h5;
  localparam logic [2:0] LT_ODD_START = 3'h6;
  localparam logic [2:0] LT_ODD_END = 3'h7;
  localparam logic [2:0] LT_ODD_MASK = 3'h2;

  // sequence framing bytes
  localparam logic [7:0] ESC_BYTE = 8'hff;
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] EOL_TAIL = 8'hff;
  localparam logic [2:0] SEQ_LAST = 3'h5;
  localparam logic [1:0] PAD_BITS = 2'h0;

  // link widths and buffer depth
  localparam int BYTE_W = 8;
  localparam int NIB_W = 5;
  localparam int FIFO_DEPTH = 32;

  // pixel average window, index of first pixel and length
  localparam logic [8:0] WIN_START_WIDE = 9'h030;
  localparam logic [8:0] WIN_LEN_WIDE = 9'h100;
  localparam logic [8:0] WIN_START_NARROW = 9'h018;
  localparam logic [8:0] WIN_LEN_NARROW = 9'h080;

  typedef enum logic [1:0] {FMT_NTSC, FMT_PAL, FMT_CIF, FMT_QCIF} ecwc_fmt_e;

  // protected command byte: fixed one, data bits, then even check bits
  function automatic logic [7:0] cmd_byte(input logic [2:0] c);
    logic [3:0] p;
    p[0] = c[2] ^ c[1] ^ c[0];
    p[1] = c[2] ^ c[1];
    p[2] = c[2] ^ c[0];
    p[3] = c[1] ^ c[0];
    return {1'b1, c, p};
  endfunction

  // six-bit half padded with a leading zero and an odd-parity trailer
  function automatic logic [7:0] num_byte(input logic [5:0] half);
    return {1'b0, half, ~(^half)};
  endfunction
endpackage

// ==== hw/ecwc_link_if.sv ====
`timescale 1ns/1ps
// nibble-serial video link; nib_en is high while the sensor drives the wires
interface ecwc_link_if;
  logic [4:0] nib;
  logic nib_en;
  modport dev_mp (output nib, output nib_en);
  modport host_mp (input nib, input nib_en);
endinterface

// ==== hw/ecwc_dev.sv ====
`timescale 1ns/1ps
// How it works
// - command byte: three data, four checks, fixed one
// - check bits give even parity over data subsets
// - one and data high nibble, checks low nibble
// - field start and end codes with their checks
// - odd field codes only in PAL or NTSC
// - host corrects single, detects double command errors
// - lone failing check means only that bit bad
// - host flips data bit by failing check pattern
// - other check patterns mean uncorrectable double error
// - line start carries twelve-bit number, two halves
// - each half gets leading zero, odd parity bit
// - line end fifth byte is central pixel average
// - line end sixth byte is all ones
// - five-wire word is byte plus two zeros
// - five-wire word goes as two nibbles, upper first
// - two all-ones words then zero precede command
// - every sequence is exactly six bytes long
// - host drops rest of field on double error

// plain synchronous fifo; out_data is valid whenever out_valid is high
module ecwc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
  localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_reg != FULL_CNT);
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage has no reset; only pointers and count define its content
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// sensor end: builds six-byte control sequences and serialises them
module ecwc_dev (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [1:0] i_fmt,
  input wire logic i_five_wire,
  input wire logic i_line_req,
  input wire logic [2:0] i_line_code,
  input wire logic [11:0] i_line_num,
  input wire logic i_eol_req,
  output logic o_req_ready,
  input wire logic i_pix_valid,
  input wire logic i_pix_first,
  input wire logic [9:0] i_pix_data,
  ecwc_link_if.dev_mp link
);
  typedef enum logic {ST_IDLE, ST_PUSH} ecwc_bld_e;

  ecwc_bld_e state_reg;
  logic [2:0] idx_reg;
  logic [2:0] code_reg;
  logic [11:0] num_reg;
  logic [7:0] avg_reg;
  logic [8:0] pix_idx_reg;
  logic [17:0] sum_reg;
  logic [4:0] lo_nib_reg;
  logic lo_pend_reg;
  logic [7:0] byte_next;
  logic [8:0] pix_idx;
  logic [8:0] win_start;
  logic [8:0] win_len;
  logic in_win;
  logic narrow;
  logic odd_ok;
  logic accept;
  logic f_in_ready;
  logic f_out_valid;
  logic [7:0] f_out_data;
  logic take;

  assign narrow = (i_fmt == ecwc_pkg::FMT_QCIF);
  assign odd_ok = (i_fmt == ecwc_pkg::FMT_PAL) || (i_fmt == ecwc_pkg::FMT_NTSC);
  assign accept = o_req_ready && (i_line_req || i_eol_req);

  // average window is centred on the active line, narrower in the small format
  assign win_start = narrow ? ecwc_pkg::WIN_START_NARROW : ecwc_pkg::WIN_START_WIDE;
  assign win_len = narrow ? ecwc_pkg::WIN_LEN_NARROW : ecwc_pkg::WIN_LEN_WIDE;
  assign pix_idx = i_pix_first ? '0 : pix_idx_reg;
  assign in_win = (pix_idx >= win_start) && (pix_idx < 9'(win_start + win_len));

  // pixel counter and window sum, restarted by the first pixel of each line
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pix_idx_reg <= '0;
      sum_reg <= '0;
    end else if (i_pix_valid) begin
      pix_idx_reg <= pix_idx + 1'b1;
      if (i_pix_first) begin
        sum_reg <= in_win ? 18'(i_pix_data) : '0;
      end else if (in_win) begin
        sum_reg <= sum_reg + 18'(i_pix_data);
      end
    end
  end

  // request capture; the average keeps its top eight of ten bits
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      code_reg <= ecwc_pkg::LT_END;
      num_reg <= '0;
      avg_reg <= '0;
    end else if (accept) begin
      if (i_line_req) begin
        // odd field codes fall back to their even twins outside PAL and NTSC
        if (!odd_ok && i_line_code[2] && i_line_code[1]) begin
          code_reg <= i_line_code & ~ecwc_pkg::LT_ODD_MASK;
        end else begin
          code_reg <= i_line_code;
        end
        num_reg <= i_line_num;
      end else begin
        code_reg <= ecwc_pkg::LT_END;
        avg_reg <= narrow ? sum_reg[16:9] : sum_reg[17:10];
      end
    end
  end

  // byte selected by position within the sequence
  always_comb begin
    unique case (idx_reg)
      3'h0, 3'h1: byte_next = ecwc_pkg::ESC_BYTE;
      3'h2: byte_next = ecwc_pkg::SYNC_BYTE;
      3'h3: byte_next = ecwc_pkg::cmd_byte(code_reg);
      3'h4: begin
        if (code_reg == ecwc_pkg::LT_END) begin
          byte_next = avg_reg;
        end else begin
          byte_next = ecwc_pkg::num_byte(num_reg[11:6]);
        end
      end
      default: begin
        if (code_reg == ecwc_pkg::LT_END) begin
          byte_next = ecwc_pkg::EOL_TAIL;
        end else begin
          byte_next = ecwc_pkg::num_byte(num_reg[5:0]);
        end
      end
    endcase
  end

  // builder: one byte per cycle into the fifo, stalled while it is full
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      idx_reg <= '0;
      o_req_ready <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          o_req_ready <= !accept;
          if (accept) begin
            state_reg <= ST_PUSH;
            idx_reg <= '0;
          end
        end
        ST_PUSH: begin
          if (f_in_ready) begin
            if (idx_reg == ecwc_pkg::SEQ_LAST) begin
              state_reg <= ST_IDLE;
              o_req_ready <= 1'b1;
            end else begin
              idx_reg <= idx_reg + 1'b1;
            end
          end
        end
      endcase
    end
  end

  ecwc_fifo #(
    .W(ecwc_pkg::BYTE_W),
    .D(ecwc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_in_valid(state_reg == ST_PUSH),
    .o_in_ready(f_in_ready),
    .i_in_data(byte_next),
    .o_out_valid(f_out_valid),
    .i_out_ready(!lo_pend_reg),
    .o_out_data(f_out_data)
  );

  assign take = f_out_valid && !lo_pend_reg;

  // serialiser: two cycles per byte, so the fifo really fills during bursts
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      link.nib <= '0;
      link.nib_en <= 1'b0;
      lo_nib_reg <= '0;
      lo_pend_reg <= 1'b0;
    end else if (take) begin
      link.nib_en <= 1'b1;
      lo_pend_reg <= 1'b1;
      if (i_five_wire) begin
        link.nib <= f_out_data[7:3];
        lo_nib_reg <= {f_out_data[2:0], ecwc_pkg::PAD_BITS};
      end else begin
        link.nib <= {1'b0, f_out_data[7:4]};
        lo_nib_reg <= {1'b0, f_out_data[3:0]};
      end
    end else if (lo_pend_reg) begin
      link.nib <= lo_nib_reg;
      lo_pend_reg <= 1'b0;
    end else begin
      link.nib <= '0;
      link.nib_en <= 1'b0;
    end
  end
endmodule

// ==== hw/ecwc_host.sv ====
`timescale 1ns/1ps
// host end: finds sync, corrects the command byte, unpacks supplementary bytes
module ecwc_host (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_five_wire,
  ecwc_link_if.host_mp link,
  output logic o_cmd_valid,
  output logic [2:0] o_line_type,
  output logic o_cmd_fixed,
  output logic o_cmd_bad,
  output logic o_num_valid,
  output logic [11:0] o_line_num,
  output logic o_num_err,
  output logic o_avg_valid,
  output logic [7:0] o_pix_avg,
  output logic o_tail_err,
  output logic o_drop_field
);
  typedef enum logic {ST_HUNT, ST_GET} ecwc_rx_e;

  ecwc_rx_e state_reg;
  logic [4:0] sh_reg [5];
  logic half_reg;
  logic [1:0] idx_reg;
  logic [4:0] hi_reg;
  logic [2:0] type_reg;
  logic [5:0] num_hi_reg;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] rx_byte;
  logic sync_hit;
  logic [3:0] syn;
  logic [2:0] fixed_type;
  logic fix_any;
  logic bad;
  logic byte_done;

  // byte seen in a pair of nibbles; five-wire drops the two pad bits
  function automatic logic [7:0] view(input logic [4:0] hi, input logic [4:0] lo,
                                      input logic five);
    return five ? {hi, lo[4:2]} : {hi[3:0], lo[3:0]};
  endfunction

  assign b0 = view(sh_reg[4], sh_reg[3], i_five_wire);
  assign b1 = view(sh_reg[2], sh_reg[1], i_five_wire);
  assign b2 = view(sh_reg[0], link.nib, i_five_wire);
  assign sync_hit = link.nib_en && (b0 == ecwc_pkg::ESC_BYTE) &&
                    (b1 == ecwc_pkg::ESC_BYTE) && (b2 == ecwc_pkg::SYNC_BYTE);
  assign rx_byte = view(hi_reg, link.nib, i_five_wire);
  assign byte_done = (state_reg == ST_GET) && link.nib_en && half_reg;

  // failing checks of the received command byte
  assign syn[0] = rx_byte[6] ^ rx_byte[5] ^ rx_byte[4] ^ rx_byte[0];
  assign syn[1] = rx_byte[6] ^ rx_byte[5] ^ rx_byte[1];
  assign syn[2] = rx_byte[6] ^ rx_byte[4] ^ rx_byte[2];
  assign syn[3] = rx_byte[5] ^ rx_byte[4] ^ rx_byte[3];

  // a lone failing check blames the check bit itself
  always_comb begin
    fixed_type = rx_byte[6:4];
    fix_any = 1'b0;
    bad = 1'b0;
    unique case (syn)
      4'h0, 4'h1, 4'h2, 4'h4, 4'h8: fix_any = (syn != 4'h0);
      4'hd: begin
        fixed_type[0] = ~rx_byte[4];
        fix_any = 1'b1;
      end
      4'hb: begin
        fixed_type[1] = ~rx_byte[5];
        fix_any = 1'b1;
      end
      4'h7: begin
        fixed_type[2] = ~rx_byte[6];
        fix_any = 1'b1;
      end
      default: bad = 1'b1;
    endcase
  end

  // history of the last five nibbles, only while the sensor drives
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 5; i++) begin
        sh_reg[i] <= '0;
      end
    end else if (link.nib_en) begin
      sh_reg[0] <= link.nib;
      for (int i = 1; i < 5; i++) begin
        sh_reg[i] <= sh_reg[i-1];
      end
    end
  end

  // framing: hunt for escape and sync, then collect three bytes
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_HUNT;
      half_reg <= 1'b0;
      idx_reg <= '0;
      hi_reg <= '0;
    end else if (link.nib_en) begin
      unique case (state_reg)
        ST_HUNT: begin
          if (sync_hit) begin
            state_reg <= ST_GET;
            half_reg <= 1'b0;
            idx_reg <= '0;
          end
        end
        ST_GET: begin
          half_reg <= !half_reg;
          if (!half_reg) begin
            hi_reg <= link.nib;
          end else if (idx_reg == 2'h2) begin
            state_reg <= ST_HUNT;
          end else begin
            idx_reg <= idx_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // decoded results; pulses last one cycle, values hold until replaced
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cmd_valid <= 1'b0;
      o_line_type <= ecwc_pkg::LT_END;
      o_cmd_fixed <= 1'b0;
      o_cmd_bad <= 1'b0;
      o_num_valid <= 1'b0;
      o_line_num <= '0;
      o_num_err <= 1'b0;
      o_avg_valid <= 1'b0;
      o_pix_avg <= '0;
      o_tail_err <= 1'b0;
      type_reg <= ecwc_pkg::LT_END;
      num_hi_reg <= '0;
    end else begin
      o_cmd_valid <= byte_done && (idx_reg == 2'h0);
      o_num_valid <= 1'b0;
      o_avg_valid <= 1'b0;
      if (byte_done) begin
        unique case (idx_reg)
          2'h0: begin
            o_line_type <= fixed_type;
            o_cmd_fixed <= fix_any;
            o_cmd_bad <= bad;
            o_num_err <= 1'b0;
            o_tail_err <= 1'b0;
            type_reg <= fixed_type;
          end
          2'h1: begin
            if (type_reg == ecwc_pkg::LT_END) begin
              o_pix_avg <= rx_byte;
              o_avg_valid <= 1'b1;
            end else begin
              num_hi_reg <= rx_byte[6:1];
              o_num_err <= rx_byte[7] || !(^rx_byte);
            end
          end
          default: begin
            if (type_reg == ecwc_pkg::LT_END) begin
              o_tail_err <= (rx_byte != ecwc_pkg::EOL_TAIL);
            end else begin
              o_line_num <= {num_hi_reg, rx_byte[6:1]};
              o_num_valid <= 1'b1;
              o_num_err <= o_num_err || rx_byte[7] || !(^rx_byte);
            end
          end
        endcase
      end
    end
  end

  // field drop: set by a double error, cleared by a clean field start
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_drop_field <= 1'b0;
    end else if (byte_done && (idx_reg == 2'h0)) begin
      if (bad) begin
        o_drop_field <= 1'b1;
      end else if (fixed_type == ecwc_pkg::LT_EVEN_START ||
                   fixed_type == ecwc_pkg::LT_ODD_START) begin
        o_drop_field <= 1'b0;
      end
    end
  end
endmodule

// ==== sim/ecwc_link_props.sv ====
`timescale 1ns/1ps
// watches the link wires; cnt_reg is the nibble index 0..11 within a sequence
module ecwc_link_props (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_five_wire,
  input wire logic [4:0] nib,
  input wire logic nib_en
);
  logic [3:0] cnt_reg;
  logic [4:0] hi_reg;
  logic [2:0] code_reg;
  logic [7:0] byte_now;

  // sequences may run back to back with no gap, so the index wraps at eleven
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn)
      cnt_reg <= 4'h0;
    else if (!nib_en)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= (cnt_reg == 4'hb) ? 4'h0 : cnt_reg + 4'h1;
  end

  // upper nibble kept for pairing
  always_ff @(posedge i_clk_sys) begin
    if (nib_en)
      hi_reg <= nib;
  end

  // line type of the sequence in flight
  always_ff @(posedge i_clk_sys) begin
    if (nib_en && cnt_reg == 4'h7)
      code_reg <= byte_now[6:4];
  end

  // byte closed by the nibble now on the wires, meaningful at odd indices
  assign byte_now = i_five_wire ? {hi_reg, nib[4:2]} : {hi_reg[3:0], nib[3:0]};

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  a_esc_sync_order: assert property (
    nib_en && cnt_reg[0] && cnt_reg < 4'h6 |-> byte_now == (cnt_reg < 4'h4 ? 8'hff : 8'h00))
    else $error("escape or sync byte wrong");
  a_cmd_even_checks: assert property (
    nib_en && cnt_reg == 4'h7 |-> byte_now[7] && byte_now[0] == ^byte_now[6:4]
      && byte_now[1] == (byte_now[6] ^ byte_now[5]) && byte_now[2] == (byte_now[6] ^ byte_now[4])
      && byte_now[3] == (byte_now[5] ^ byte_now[4]))
    else $error("command byte malformed");
  a_cmd_upper_first: assert property (
    nib_en && cnt_reg == 4'h6 |-> (i_five_wire ? nib[4] : nib[3] && !nib[4]))
    else $error("command upper nibble out of place");
  a_num_odd_parity: assert property (
    nib_en && code_reg != 3'h0 && (cnt_reg == 4'h9 || cnt_reg == 4'hb) |-> !byte_now[7] && ^byte_now)
    else $error("line number byte malformed");
  a_eol_tail_ones: assert property (
    nib_en && code_reg == 3'h0 && cnt_reg == 4'hb |-> byte_now == 8'hff)
    else $error("line end tail not all ones");
  a_pad_bits_zero: assert property (
    nib_en && i_five_wire && cnt_reg[0] |-> nib[1:0] == 2'h0)
    else $error("five-wire pad bits not zero");
  a_seq_whole: assert property (
    $rose(nib_en) |-> nib_en [*8] ##1 nib_en [*4])
    else $error("sequence shorter than six bytes");
  a_seq_end_index: assert property (
    $fell(nib_en) |-> $past(cnt_reg) == 4'hb)
    else $error("link released mid sequence");
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
// sensor end feeds host end; a second host gets hand-made faulty bytes
module testbench;
  typedef struct packed {
    logic eol;
    logic [1:0] fmt;
    logic five;
    logic [2:0] code;
    logic [11:0] val;
    logic [2:0] ty;
  } ecwc_row_s;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic [1:0] i_fmt = 2'h1;
  logic i_five_wire = 1'b0;
  logic i_line_req = 1'b0;
  logic i_eol_req = 1'b0;
  logic [2:0] i_line_code = 3'h0;
  logic [11:0] i_line_num = 12'h000;
  logic i_pix_valid = 1'b0;
  logic i_pix_first = 1'b0;
  logic [9:0] i_pix_data = 10'h000;
  logic o_req_ready, h_cmd_valid, h_num_valid, h_num_err, h_avg_valid, h_tail_err;
  logic h2_fixed, h2_bad, h2_drop;
  logic [2:0] h_line_type, h2_type;
  logic [11:0] h_line_num;
  logic [7:0] h_pix_avg;
  logic [11:0] q_num[$];
  logic [2:0] q_type[$];
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int nib_cnt = 0;
  // odd field codes outside PAL/NTSC expect their even twin; line end rows carry a pixel level
  ecwc_row_s rows[14] = '{
    '{1'h0, 2'h1, 1'h0, 3'h1, 12'hfff, 3'h1}, '{1'h0, 2'h1, 1'h0, 3'h2, 12'h000, 3'h2},
    '{1'h0, 2'h1, 1'h0, 3'h3, 12'h03f, 3'h3}, '{1'h0, 2'h1, 1'h0, 3'h4, 12'hfc0, 3'h4},
    '{1'h0, 2'h1, 1'h0, 3'h5, 12'h555, 3'h5}, '{1'h0, 2'h1, 1'h0, 3'h6, 12'haaa, 3'h6},
    '{1'h0, 2'h1, 1'h0, 3'h7, 12'h001, 3'h7}, '{1'h0, 2'h0, 1'h1, 3'h6, 12'h123, 3'h6},
    '{1'h0, 2'h0, 1'h1, 3'h7, 12'h7ff, 3'h7}, '{1'h0, 2'h2, 1'h1, 3'h7, 12'h456, 3'h5},
    '{1'h0, 2'h3, 1'h0, 3'h6, 12'h800, 3'h4}, '{1'h1, 2'h1, 1'h0, 3'h0, 12'h2a5, 3'h0},
    '{1'h1, 2'h3, 1'h1, 3'h0, 12'h3fd, 3'h0}, '{1'h1, 2'h2, 1'h1, 3'h0, 12'h004, 3'h0}};
  logic [7:0] masks[10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h03, 8'h30};

  ecwc_link_if link ();
  ecwc_link_if link2 ();
  ecwc_dev ecwc_dev_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_fmt(i_fmt),
    .i_five_wire(i_five_wire), .i_line_req(i_line_req), .i_line_code(i_line_code),
    .i_line_num(i_line_num), .i_eol_req(i_eol_req), .o_req_ready(o_req_ready),
    .i_pix_valid(i_pix_valid), .i_pix_first(i_pix_first), .i_pix_data(i_pix_data), .link(link));
  ecwc_host ecwc_host_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_five_wire(i_five_wire),
    .link(link), .o_cmd_valid(h_cmd_valid), .o_line_type(h_line_type), .o_cmd_fixed(),
    .o_cmd_bad(), .o_num_valid(h_num_valid), .o_line_num(h_line_num), .o_num_err(h_num_err),
    .o_avg_valid(h_avg_valid), .o_pix_avg(h_pix_avg), .o_tail_err(h_tail_err), .o_drop_field());
  // fault host, fed by the bench in four-wire form
  ecwc_host ecwc_host_inst2 (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_five_wire(1'b0),
    .link(link2), .o_cmd_valid(), .o_line_type(h2_type), .o_cmd_fixed(h2_fixed),
    .o_cmd_bad(h2_bad), .o_num_valid(), .o_line_num(), .o_num_err(), .o_avg_valid(),
    .o_pix_avg(), .o_tail_err(), .o_drop_field(h2_drop));
  ecwc_link_props ecwc_link_props_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_five_wire(i_five_wire), .nib(link.nib), .nib_en(link.nib_en));

  initial forever #5 i_clk_sys = ~i_clk_sys;

  // results gathered as the host announces them; avg shares the value queue
  always @(posedge i_clk_sys) begin
    if (h_num_valid === 1'b1) q_num.push_back(h_line_num);
    if (h_avg_valid === 1'b1) q_num.push_back({4'h0, h_pix_avg});
    if (h_cmd_valid === 1'b1) q_type.push_back(h_line_type);
    // nibble cycles on the link, to prove the buffer neither drops nor repeats bytes
    if (link.nib_en === 1'b1) nib_cnt++;
  end

  // ceiling far above the few thousand cycles the tests need
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk({11'h0, got}, {11'h0, exp}, what);
  endtask

  // waits for ready at a falling edge, then holds the request over one rising edge
  task automatic req(input logic eol, input logic [2:0] code, input logic [11:0] num);
    for (int k = 0; k < 300 && o_req_ready !== 1'b1; k++) @(negedge i_clk_sys);
    i_line_req = !eol;
    i_eol_req = eol;
    i_line_code = code;
    i_line_num = num;
    @(negedge i_clk_sys);
    i_line_req = 1'b0;
    i_eol_req = 1'b0;
  endtask

  task automatic get(input logic [11:0] exp, input logic [2:0] ty);
    for (int k = 0; k < 400 && q_num.size() == 0; k++) @(negedge i_clk_sys);
    if (q_num.size() == 0) q_num.push_back('x);
    if (q_type.size() == 0) q_type.push_back('x);
    chk({9'h0, q_type.pop_front()}, {9'h0, ty}, "line type");
    chk(q_num.pop_front(), exp, "value");
  endtask

  // pixels outside the centre window sit at 3fe, one below full scale, so a shifted window shows
  task automatic pixels(input logic [9:0] v, input int len);
    for (int i = 0; i < len; i++) begin
      @(negedge i_clk_sys);
      i_pix_valid = 1'b1;
      i_pix_first = (i == 0);
      i_pix_data = (i >= len * 3 / 22 && i < len * 19 / 22) ? v : 10'h3fe;
    end
    @(negedge i_clk_sys);
    i_pix_valid = 1'b0;
  endtask

  // one byte on the fault link as two nibbles, upper first
  task automatic raw(input logic [7:0] b);
    @(negedge i_clk_sys);
    link2.nib = {1'h0, b[7:4]};
    link2.nib_en = 1'b1;
    @(negedge i_clk_sys);
    link2.nib = {1'h0, b[3:0]};
  endtask

  task automatic raw_seq(input logic [7:0] cmd);
    raw(8'hff);
    raw(8'hff);
    raw(8'h00);
    raw(cmd);
    raw(8'h01);
    raw(8'h01);
    @(negedge i_clk_sys);
    link2.nib_en = 1'b0;
    link2.nib = ~link2.nib;
    repeat (3) @(negedge i_clk_sys);
  endtask

  initial begin
    int ones;
    int waits;
    int max_wait;
    int base;
    link2.nib = 5'h00;
    link2.nib_en = 1'b0;
    repeat (8) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    foreach (rows[r]) begin
      i_fmt = rows[r].fmt;
      i_five_wire = rows[r].five;
      if (rows[r].eol) pixels(rows[r].val[9:0], rows[r].fmt == 2'h3 ? 176 : 352);
      req(rows[r].eol, rows[r].code, rows[r].val);
      get(rows[r].eol ? {4'h0, rows[r].val[9:2]} : rows[r].val, rows[r].ty);
      repeat (4) @(negedge i_clk_sys);
      chk_bit(rows[r].eol ? h_tail_err : h_num_err, 1'b0, "supp error");
      $display("row %0d done", r);
    end
    // back-to-back lines outrun the link and fill the buffer; a request held while busy must vanish
    // without a stall ready comes back after five falling edges, more means the buffer was full
    base = nib_cnt;
    max_wait = 0;
    for (int r = 0; r < 20; r++) begin
      waits = 0;
      while (o_req_ready !== 1'b1 && waits < 300) begin
        @(negedge i_clk_sys);
        waits++;
      end
      if (waits > max_wait) max_wait = waits;
      i_line_req = 1'b1;
      i_line_code = 3'h3;
      i_line_num = 12'h100 + 12'(r);
      @(negedge i_clk_sys);
      i_line_num = 12'hbad;
      @(negedge i_clk_sys);
      i_line_req = 1'b0;
    end
    for (int r = 0; r < 20; r++) get(12'h100 + 12'(r), 3'h3);
    repeat (4) @(negedge i_clk_sys);
    chk_bit(q_num.size() == 0, 1'b1, "refused request sent");
    chk_bit(max_wait > 5, 1'b1, "full buffer stalls requests");
    chk(12'(nib_cnt - base), 12'h0f0, "burst nibble count");
    chk_bit(link.nib_en, 1'b0, "link idle after drain");
    $display("burst test done");
    // single flips are repaired, double flips condemn the field
    foreach (masks[m]) begin
      raw_seq(8'hb6 ^ masks[m]);
      ones = $countones(masks[m]);
      chk_bit(h2_fixed, ones == 1 && masks[m] != 8'h80, "fixed");
      chk_bit(h2_bad, ones == 2, "bad");
      chk_bit(h2_drop, ones == 2, "drop");
      if (ones < 2) chk({9'h0, h2_type}, 12'h003, "repaired type");
    end
    raw_seq(8'hc7);
    chk_bit(h2_drop, 1'b0, "drop cleared");
    chk({9'h0, h2_type}, 12'h004, "field start type");
    $display("fault test done");
    // reset in mid sequence returns both ends to quiet
    req(1'h0, 3'h3, 12'h00f);
    repeat (5) @(negedge i_clk_sys);
    i_rstn = 1'b0;
    @(negedge i_clk_sys);
    chk_bit(o_req_ready, 1'b0, "ready in reset");
    chk_bit(link.nib_en, 1'b0, "link in reset");
    chk({9'h0, h_line_type}, 12'h000, "type in reset");
    i_rstn = 1'b1;
    q_num.delete();
    q_type.delete();
    @(negedge i_clk_sys);
    chk_bit(o_req_ready, 1'b1, "ready after reset");
    req(1'h0, 3'h2, 12'h0ab);
    get(12'h0ab, 3'h2);
    $display("reset test done");
    wrap_up();
  end
endmodule
